// [design/dce_pkg.sv]
// Package of constants and carrier types for the debug command engine
package dce_pkg;
  // ==========================================================
  // Command codes
  localparam logic [7:0] CMD_REV = 8'h00;
  localparam logic [7:0] CMD_STAT = 8'h02;
  localparam logic [7:0] CMD_RTC = 8'h03;
  localparam logic [7:0] CMD_WCTL = 8'h04;
  localparam logic [7:0] CMD_RCTL = 8'h05;
  localparam logic [7:0] CMD_WPC = 8'h06;
  localparam logic [7:0] CMD_RPC = 8'h07;
  localparam logic [7:0] CMD_WREG = 8'h08;
  localparam logic [7:0] CMD_RREG = 8'h09;
  localparam logic [7:0] CMD_WPM = 8'h0A;
  localparam logic [7:0] CMD_RPM = 8'h0B;
  localparam logic [7:0] CMD_WDM = 8'h0C;
  localparam logic [7:0] CMD_RDM = 8'h0D;
  localparam logic [7:0] CMD_CRC = 8'h0E;
  localparam logic [7:0] CMD_STEP = 8'h10;
  localparam logic [7:0] CMD_STUFF = 8'h11;
  localparam logic [7:0] CMD_EXEC = 8'h12;
  // ==========================================================
  // Control and status fields
  localparam int CTL_HALT_POS = 7;
  localparam int CTL_BREAKPOINT_ENABLE_BIT_POS = 6;
  localparam int CTL_NOTIFY_POS = 5;
  localparam int CTL_RST_POS = 0;
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [7:0] CTL_WMASK = 8'hE1;
  localparam int STAT_HALT_POS = 7;
  localparam int STAT_LPH_POS = 6;
  localparam int STAT_LOCKH_POS = 5;
  localparam logic [7:0] ALL_ONES_BYTE = 8'hFF;
  localparam logic [7:0] NOTIFY_BYTE = 8'hFF;
  localparam logic [15:0] REV_DEFAULT = 16'h0100; // Arbitrary value
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] RTC_MAX = 16'hFFFF;
  localparam logic [15:0] RTC_ZERO = 16'h0000;
  // ==========================================================
  // Memory bus carrier: space select, address, write data, strobes
  typedef enum logic [1:0] {
    DCE_SP_REG = 2'b00,
    DCE_SP_PM = 2'b01,
    DCE_SP_DM = 2'b10
  } dce_space_t;
  typedef struct packed {
    dce_space_t space;
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } dce_mem_req_t;
endpackage

// [design/dce_rtc.sv]
// Saturating runtime counter of system clock cycles
`timescale 1ns/1ps
`default_nettype none
module dce_rtc #(
  parameter int WIDTH = 16
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clear,
  input wire logic run,
  input wire logic load,
  input wire logic [WIDTH-1:0] load_val,
  output logic [WIDTH-1:0] count
);
  import dce_pkg::*;
  logic [WIDTH-1:0] count_ff;
  // ==========================================================
  // Counter: load wins, clear on leaving halt, saturate at all ones
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      count_ff <= '0;
    end else if (load) begin
      count_ff <= load_val;
    end else if (clear) begin
      count_ff <= '0;
    end else if (run && count_ff != {WIDTH{1'b1}}) begin
      count_ff <= count_ff + 1'b1;
    end
  end
  assign count = count_ff;
endmodule
`default_nettype wire

// [design/dce_crc.sv]
// CRC-CCITT byte update engine, one byte per clock
`timescale 1ns/1ps
`default_nettype none
module dce_crc (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic init,
  input wire logic en,
  input wire logic [7:0] data,
  output logic [15:0] crc
);
  import dce_pkg::*;
  logic [15:0] crc_ff;
  logic [15:0] nxt_crc;
  // ==========================================================
  // Bitwise MSB-first update; unrolled by the loop for a one-cycle byte
  always_comb begin
    nxt_crc = crc_ff ^ {data, 8'h00};
    for (int i = 0; i < 8; i++) begin
      nxt_crc = nxt_crc[15] ? ((nxt_crc << 1) ^ CRC_POLY) : (nxt_crc << 1);
    end
  end
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      crc_ff <= CRC_INIT;
    end else if (init) begin
      crc_ff <= CRC_INIT;
    end else if (en) begin
      crc_ff <= nxt_crc;
    end
  end
  assign crc = crc_ff;
endmodule
`default_nettype wire

// [design/dce_engine.sv]
// Debug command engine: byte command interpreter of the on-chip debugger
// Operation
// - 00H returns revision; 02H returns status
// - Sixteen-bit saturating cycle counter, read 03H
// - Memory, register, step commands overwrite counter
// - 04H writes control, 05H reads; lock
// - 06H loads PC when halted, unlocked
// - 07H returns PC, else all ones
// - Register write framing; discard unless halted
// - Locked register writes only to flash control
// - 09H register read; ones if blocked
// - 0AH program write needs flash unlocked
// - 0BH program read; ones if blocked
// - 0CH data write; discard if blocked
// - 0DH data read; ones only if running
// - 0EH CRC of program memory
// - 10H steps one instruction when allowed
// - 11H stuffs opcode byte, rest fetched
// - 12H executes sent instruction; else one
// - Halt bit stops fetch; set on break
// - Breakpoint enable gates break opcode
// - Notify byte on breakpoint when enabled
// - Reset bit runs device reset, self-clears
// - Counter runs outside halt, stops saturated
// - Status: halted, low-power halt, lock honoured
`timescale 1ns/1ps
`default_nettype none
module dce_engine #(
  parameter logic [15:0] REV_WORD = dce_pkg::REV_DEFAULT,
  parameter logic [15:0] PM_BYTES = 16'hFFFF,
  parameter logic [11:0] FLASH_CTL_LO = 12'hFF8,
  parameter logic [11:0] FLASH_CTL_HI = 12'hFFB
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic rx_valid,
  input wire logic [7:0] rx_byte,
  output logic tx_valid,
  output logic [7:0] tx_byte,
  input wire logic tx_ready,
  input wire logic read_lock_option,
  input wire logic cpu_lowpower_halt,
  input wire logic break_decoded,
  input wire logic flash_unlocked,
  input wire logic [15:0] cpu_pc,
  output logic pc_load,
  output logic [15:0] pc_load_val,
  output logic fetch_halt,
  output logic step_req,
  output logic stuff_req,
  output logic exec_req,
  output logic [7:0] instr_byte,
  output logic instr_byte_valid,
  input wire logic [2:0] instr_len,
  input wire logic instr_done,
  output logic device_reset_req,
  input wire logic device_reset_done,
  output dce_pkg::dce_mem_req_t mem_req,
  input wire logic [7:0] mem_rdata
);
  import dce_pkg::*;
  typedef enum logic [3:0] {
    ST_CMD = 4'h0, ST_ARG = 4'h1, ST_WDATA = 4'h2, ST_RD_REQ = 4'h3,
    ST_RD_WAIT = 4'h4, ST_TX = 4'h5, ST_CRC = 4'h6, ST_CPU = 4'h7,
    ST_EXEC_BYTES = 4'h8
  } dce_state_t;
  dce_state_t state_ff;
  logic [7:0] cmd_ff, ctl_ff;
  logic [1:0] argn_ff;
  logic [2:0] argi_ff;
  logic [15:0] addr_ff, cnt_ff, txw_ff, crc_addr_ff;
  logic [16:0] left_ff;
  logic tx_two_ff, tx_hi_ff, tx_valid_ff, rd_ones_ff, notify_ff, crc_en_ff;
  logic [7:0] tx_byte_ff;
  logic [2:0] ilen_ff;
  logic lock, halted, wr_ok, rd_ones_now;
  logic [15:0] crc_val, rtc_val;
  logic rtc_load;
  // ==========================================================
  // Derived conditions
  assign lock = read_lock_option;
  assign halted = ctl_ff[CTL_HALT_POS];
  assign fetch_halt = halted;
  assign device_reset_req = ctl_ff[CTL_RST_POS];
  // Write gate per command, evaluated at each data byte
  always_comb begin
    case (cmd_ff)
      CMD_WREG: wr_ok = halted && (!lock || (addr_ff[11:0] >= FLASH_CTL_LO
                        && addr_ff[11:0] <= FLASH_CTL_HI));
      CMD_WPM: wr_ok = halted && !lock && flash_unlocked;
      CMD_WDM: wr_ok = halted && !lock;
      default: wr_ok = 1'b0;
    endcase
  end
  // Read blocking: data memory read ignores the lock
  assign rd_ones_now = (cmd_ff == CMD_RDM) ? !halted : (!halted || lock);
  // ==========================================================
  // Runtime counter; overwritten by the memory/CPU commands
  assign rtc_load = (state_ff == ST_WDATA || state_ff == ST_RD_REQ || state_ff == ST_CRC
                     || state_ff == ST_CPU);
  dce_rtc #(.WIDTH(16)) u_rtc (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .clear(state_ff == ST_ARG && cmd_ff == CMD_WCTL && rx_valid && halted && !lock
           && !rx_byte[CTL_HALT_POS]),
    .run(!halted),
    .load(rtc_load),
    .load_val(left_ff[15:0]),
    .count(rtc_val)
  );
  dce_crc u_crc (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .init(state_ff == ST_CMD),
    .en(crc_en_ff),
    .data(mem_rdata),
    .crc(crc_val)
  );
  // ==========================================================
  // Control register: host writes, break sets halt, reset self-clears
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ctl_ff <= CTL_RESET;
    end else begin
      if (state_ff == ST_ARG && cmd_ff == CMD_WCTL && rx_valid) begin
        ctl_ff <= rx_byte & CTL_WMASK;
        if (lock && halted) begin
          ctl_ff[CTL_HALT_POS] <= 1'b1;
        end
      end else if (device_reset_done && ctl_ff[CTL_RST_POS]) begin
        ctl_ff[CTL_RST_POS] <= 1'b0;
      end
      if (break_decoded && ctl_ff[CTL_BREAKPOINT_ENABLE_BIT_POS]) begin
        ctl_ff[CTL_HALT_POS] <= 1'b1;
      end
    end
  end
  // Notify pending on breakpoint, sent when the transmitter is free
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      notify_ff <= 1'b0;
    end else if (break_decoded && ctl_ff[CTL_BREAKPOINT_ENABLE_BIT_POS] && ctl_ff[CTL_NOTIFY_POS]
                 && !halted) begin
      notify_ff <= 1'b1;
    end else if (state_ff == ST_CMD && !tx_valid_ff) begin
      notify_ff <= 1'b0;
    end
  end
  // ==========================================================
  // Command sequencer
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_ff <= ST_CMD;
      cmd_ff <= 8'h00;
      argn_ff <= 2'd0;
      argi_ff <= 3'd0;
      addr_ff <= 16'h0000;
      cnt_ff <= 16'h0000;
      left_ff <= 17'h00000;
      txw_ff <= 16'h0000;
      tx_two_ff <= 1'b0;
      tx_hi_ff <= 1'b0;
      tx_valid_ff <= 1'b0;
      tx_byte_ff <= 8'h00;
      rd_ones_ff <= 1'b0;
      crc_en_ff <= 1'b0;
      crc_addr_ff <= 16'h0000;
      ilen_ff <= 3'd0;
    end else begin
      crc_en_ff <= 1'b0;
      if (tx_valid_ff && tx_ready) begin
        tx_valid_ff <= 1'b0;
      end
      case (state_ff)
        ST_CMD: begin
          argi_ff <= 3'd0;
          if (notify_ff && !tx_valid_ff) begin
            tx_byte_ff <= NOTIFY_BYTE;
            tx_valid_ff <= 1'b1;
          end else if (rx_valid) begin
            cmd_ff <= rx_byte;
            case (rx_byte)
              CMD_REV: begin
                txw_ff <= REV_WORD;
                tx_two_ff <= 1'b1;
                state_ff <= ST_TX;
              end
              CMD_STAT: begin
                txw_ff <= {8'h00, halted, cpu_lowpower_halt, !lock, 5'b00000};
                tx_two_ff <= 1'b0;
                state_ff <= ST_TX;
              end
              CMD_RTC: begin
                txw_ff <= rtc_val;
                tx_two_ff <= 1'b1;
                state_ff <= ST_TX;
              end
              CMD_RCTL: begin
                txw_ff <= {8'h00, ctl_ff};
                tx_two_ff <= 1'b0;
                state_ff <= ST_TX;
              end
              CMD_RPC: begin
                txw_ff <= (halted && !lock) ? cpu_pc : RTC_MAX;
                tx_two_ff <= 1'b1;
                state_ff <= ST_TX;
              end
              CMD_WCTL: begin
                argn_ff <= 2'd0;
                state_ff <= ST_ARG;
              end
              CMD_WPC, CMD_STUFF: begin
                argn_ff <= (rx_byte == CMD_WPC) ? 2'd1 : 2'd0;
                state_ff <= ST_ARG;
              end
              CMD_WREG, CMD_RREG: begin
                argn_ff <= 2'd2;
                state_ff <= ST_ARG;
              end
              CMD_WPM, CMD_RPM, CMD_WDM, CMD_RDM: begin
                argn_ff <= 2'd3;
                state_ff <= ST_ARG;
              end
              CMD_CRC: begin
                crc_addr_ff <= 16'h0000;
                left_ff <= {1'b0, PM_BYTES} + 17'd1;
                state_ff <= halted ? ST_CRC : ST_TX;
                txw_ff <= RTC_MAX;
                tx_two_ff <= 1'b1;
              end
              CMD_STEP: begin
                state_ff <= (halted && !lock) ? ST_CPU : ST_CMD;
              end
              CMD_EXEC: begin
                argn_ff <= 2'd0;
                state_ff <= ST_EXEC_BYTES;
              end
              default: state_ff <= ST_CMD;
            endcase
          end
        end
        ST_ARG: if (rx_valid) begin
          argi_ff <= argi_ff + 3'd1;
          case (argi_ff)
            3'd0: addr_ff[15:8] <= rx_byte;
            3'd1: addr_ff[7:0] <= rx_byte;
            3'd2: cnt_ff[15:8] <= rx_byte;
            default: cnt_ff[7:0] <= rx_byte;
          endcase
          if (argi_ff == 3'(argn_ff)) begin
            if (cmd_ff == CMD_WCTL) begin
              state_ff <= ST_CMD;
            end else if (cmd_ff == CMD_WPC) begin
              state_ff <= ST_CMD;
            end else if (cmd_ff == CMD_STUFF) begin
              state_ff <= (halted && !lock) ? ST_CPU : ST_CMD;
            end else if (argn_ff == 2'd2) begin
              left_ff <= (rx_byte == 8'h00) ? 17'd256 : {9'h000, rx_byte};
              addr_ff <= {4'h0, addr_ff[11:8], addr_ff[7:0]};
              state_ff <= (cmd_ff == CMD_WREG) ? ST_WDATA : ST_RD_REQ;
            end else begin
              left_ff <= ({cnt_ff[15:8], rx_byte} == 16'h0000) ? 17'h10000
                         : {1'b0, cnt_ff[15:8], rx_byte};
              state_ff <= (cmd_ff == CMD_WPM || cmd_ff == CMD_WDM) ? ST_WDATA : ST_RD_REQ;
            end
          end
        end
        ST_WDATA: if (rx_valid) begin
          addr_ff <= addr_ff + 16'd1;
          left_ff <= left_ff - 17'd1;
          if (left_ff == 17'd1) begin
            state_ff <= ST_CMD;
          end
        end
        ST_RD_REQ: if (!tx_valid_ff) begin
          rd_ones_ff <= rd_ones_now;
          state_ff <= ST_RD_WAIT;
        end
        ST_RD_WAIT: begin
          tx_byte_ff <= rd_ones_ff ? ALL_ONES_BYTE : mem_rdata;
          tx_valid_ff <= 1'b1;
          addr_ff <= addr_ff + 16'd1;
          left_ff <= left_ff - 17'd1;
          state_ff <= (left_ff == 17'd1) ? ST_CMD : ST_RD_REQ;
        end
        ST_TX: if (!tx_valid_ff) begin
          tx_byte_ff <= (tx_two_ff && !tx_hi_ff) ? txw_ff[15:8] : txw_ff[7:0];
          tx_valid_ff <= 1'b1;
          if (tx_two_ff && !tx_hi_ff) begin
            tx_hi_ff <= 1'b1;
          end else begin
            tx_hi_ff <= 1'b0;
            state_ff <= ST_CMD;
          end
        end
        ST_CRC: if (left_ff != 17'd0) begin
          crc_en_ff <= 1'b1;
          crc_addr_ff <= crc_addr_ff + 16'd1;
          left_ff <= left_ff - 17'd1;
        end else if (!crc_en_ff) begin
          state_ff <= ST_TX; // Last byte folded, result captured below
        end
        ST_EXEC_BYTES: if (rx_valid) begin
          if (argi_ff == 3'd0) begin
            ilen_ff <= (halted && !lock) ? instr_len : 3'd1;
          end
          argi_ff <= argi_ff + 3'd1;
          // First byte uses the live length, the latch lags a cycle
          if ((argi_ff == 3'd0 && !(halted && !lock))
              || argi_ff + 3'd1 == ((argi_ff == 3'd0) ? instr_len : ilen_ff)) begin
            state_ff <= (halted && !lock) ? ST_CPU : ST_CMD;
          end
        end
        ST_CPU: if (instr_done) begin
          state_ff <= ST_CMD;
        end
        default: state_ff <= ST_CMD;
      endcase
      if (state_ff == ST_CRC && left_ff == 17'd0) begin
        txw_ff <= crc_val;
      end
    end
  end
  // ==========================================================
  // Outputs toward CPU and memory
  assign pc_load = state_ff == ST_ARG && cmd_ff == CMD_WPC && rx_valid && argi_ff == 3'd1
                   && halted && !lock;
  assign pc_load_val = {addr_ff[15:8], rx_byte};
  assign step_req = state_ff == ST_CMD && rx_valid && rx_byte == CMD_STEP && halted && !lock;
  assign stuff_req = state_ff == ST_ARG && cmd_ff == CMD_STUFF && rx_valid && halted
                     && !lock;
  assign exec_req = state_ff == ST_EXEC_BYTES && halted && !lock;
  assign instr_byte = rx_byte;
  assign instr_byte_valid = rx_valid && halted && !lock
                            && ((state_ff == ST_ARG && cmd_ff == CMD_STUFF)
                            || state_ff == ST_EXEC_BYTES);
  assign tx_valid = tx_valid_ff;
  assign tx_byte = tx_byte_ff;
  always_comb begin
    mem_req.space = (cmd_ff == CMD_WREG || cmd_ff == CMD_RREG) ? DCE_SP_REG
                    : (cmd_ff == CMD_WDM || cmd_ff == CMD_RDM) ? DCE_SP_DM : DCE_SP_PM;
    mem_req.addr = (state_ff == ST_CRC) ? crc_addr_ff : addr_ff;
    mem_req.wdata = rx_byte;
    mem_req.wr = state_ff == ST_WDATA && rx_valid && wr_ok;
    mem_req.rd = (state_ff == ST_RD_REQ && !tx_valid_ff)
                 || (state_ff == ST_CRC && left_ff != 17'd0);
  end
endmodule
`default_nettype wire

// [test/dce_engine_assertions.sv]
// Port checker of the debug command engine, bound to its top module
`timescale 1ns/1ps
`default_nettype none
module dce_engine_assertions
  import dce_pkg::*;
#(
  parameter logic [11:0] FLASH_CTL_LO = 12'hFF8,
  parameter logic [11:0] FLASH_CTL_HI = 12'hFFB
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic tx_valid,
  input wire logic [7:0] tx_byte,
  input wire logic tx_ready,
  input wire logic read_lock_option,
  input wire logic flash_unlocked,
  input wire logic pc_load,
  input wire logic fetch_halt,
  input wire logic step_req,
  input wire logic instr_byte_valid,
  input wire logic device_reset_req,
  input wire logic device_reset_done,
  input wire dce_pkg::dce_mem_req_t mem_req
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);
  // ==========================================
  // Reply byte offer and hold
  sequence s_offer;
    tx_valid && !tx_ready;
  endsequence
  sequence s_hold;
    tx_valid && $stable(tx_byte);
  endsequence
  a_tx_byte_held: assert property (s_offer |=> s_hold)
    else $error("reply byte dropped before taken");
  // Reset check cannot be gated by the reset itself
  a_reset_quiet: assert property (disable iff (1'b0) sys_rst |=> !tx_valid && !fetch_halt)
    else $error("outputs not quiet after reset");
  a_lock_halt_sticky: assert property (fetch_halt && read_lock_option |=> fetch_halt)
    else $error("halt cleared while locked");
  a_reset_bit_clears: assert property (device_reset_done |=> !device_reset_req)
    else $error("reset bit stuck after reset end");
  a_pc_load_gate: assert property (pc_load |-> fetch_halt && !read_lock_option)
    else $error("pc loaded while blocked");
  a_step_gate: assert property (step_req |-> fetch_halt && !read_lock_option)
    else $error("step while blocked");
  a_instr_gate: assert property (instr_byte_valid |-> fetch_halt && !read_lock_option)
    else $error("instruction byte while blocked");
  a_write_gate: assert property (mem_req.wr |-> fetch_halt)
    else $error("write while running");
  a_lock_reg_window: assert property (mem_req.wr && read_lock_option |->
      mem_req.space == DCE_SP_REG && mem_req.addr[11:0] >= FLASH_CTL_LO &&
      mem_req.addr[11:0] <= FLASH_CTL_HI)
    else $error("locked write outside flash control");
  a_pm_write_gate: assert property (mem_req.wr && mem_req.space == DCE_SP_PM |->
      flash_unlocked)
    else $error("program write with flash locked");
endmodule
bind dce_engine dce_engine_assertions #(
  .FLASH_CTL_LO(FLASH_CTL_LO),
  .FLASH_CTL_HI(FLASH_CTL_HI)
) dce_engine_assertions_i (
  .core_clk(core_clk),
  .sys_rst(sys_rst),
  .tx_valid(tx_valid),
  .tx_byte(tx_byte),
  .tx_ready(tx_ready),
  .read_lock_option(read_lock_option),
  .flash_unlocked(flash_unlocked),
  .pc_load(pc_load),
  .fetch_halt(fetch_halt),
  .step_req(step_req),
  .instr_byte_valid(instr_byte_valid),
  .device_reset_req(device_reset_req),
  .device_reset_done(device_reset_done),
  .mem_req(mem_req)
);
`default_nettype wire

// [test/dce_cpu_model.sv]
// Behavioural CPU, memory and byte transport around the engine
`timescale 1ns/1ps
`default_nettype none
module dce_cpu_model
  import dce_pkg::*;
#(
  parameter logic [15:0] PC_INIT = 16'h0200
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire dce_pkg::dce_mem_req_t mem_req,
  input wire logic pc_load,
  input wire logic [15:0] pc_load_val,
  input wire logic step_req,
  input wire logic instr_byte_valid,
  input wire logic device_reset_req,
  input wire logic [7:0] rx_byte,
  output logic [15:0] cpu_pc,
  output logic [7:0] mem_rdata,
  output logic [2:0] instr_len,
  output logic instr_done,
  output logic device_reset_done,
  output logic tx_ready
);
  logic [3:0] cnt_ff;
  // Opcode length 1..4 from its low bits
  assign instr_len = {1'b0, rx_byte[1:0]} + 3'h1;
  // Transport stalls one cycle in four; reset ends on a count wrap
  always_ff @(posedge core_clk) begin
    cnt_ff <= sys_rst ? 4'h0 : cnt_ff + 4'h1;
    tx_ready <= cnt_ff[1:0] != 2'h3;
    device_reset_done <= device_reset_req && !device_reset_done && cnt_ff == 4'hF;
    instr_done <= step_req | instr_byte_valid;
  end
  // Read data one cycle after rd, inverted junk otherwise so no stale byte passes
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      mem_rdata <= 8'hA5;
    end else begin
      mem_rdata <= mem_req.rd ? (mem_req.addr[7:0] ^ 8'h5A) : ~mem_rdata;
    end
  end
  // Program counter follows loads and steps
  always_ff @(posedge core_clk) begin
    cpu_pc <= sys_rst ? PC_INIT : pc_load ? pc_load_val : step_req ? cpu_pc + 16'h1 : cpu_pc;
  end
endmodule
`default_nettype wire

// [test/dce_engine_tb_top.sv]
// Self-checking testbench of the debug command engine
`timescale 1ns/1ps
`default_nettype none
module dce_engine_tb_top;
  import dce_pkg::*;
  logic core_clk, sys_rst, rx_valid, tx_valid, tx_ready, lock, lph, break_opcode, fl_unl;
  logic pc_load, fetch_halt, step_req, instr_byte_valid, instr_done, rst_req, rst_done;
  logic [7:0] rx_byte, tx_byte, instr_byte, mem_rdata, b;
  logic [15:0] cpu_pc, pc_load_val, a, v1, v2;
  logic [2:0] instr_len;
  dce_mem_req_t mem_req;
  int seed, err_total, checks, cyc;
  localparam logic [15:0] PMB = 16'h000F;
  dce_engine #(.PM_BYTES(PMB)) dce_engine_i (.core_clk(core_clk), .sys_rst(sys_rst),
    .rx_valid(rx_valid), .rx_byte(rx_byte), .tx_valid(tx_valid), .tx_byte(tx_byte),
    .tx_ready(tx_ready), .read_lock_option(lock), .cpu_lowpower_halt(lph),
    .break_decoded(break_opcode), .flash_unlocked(fl_unl), .cpu_pc(cpu_pc), .pc_load(pc_load),
    .pc_load_val(pc_load_val), .fetch_halt(fetch_halt), .step_req(step_req),
    .stuff_req(), .exec_req(), .instr_byte(instr_byte), .instr_byte_valid(instr_byte_valid),
    .instr_len(instr_len), .instr_done(instr_done), .device_reset_req(rst_req),
    .device_reset_done(rst_done), .mem_req(mem_req), .mem_rdata(mem_rdata));
  dce_cpu_model dce_cpu_model_i (.core_clk(core_clk), .sys_rst(sys_rst), .mem_req(mem_req),
    .pc_load(pc_load), .pc_load_val(pc_load_val), .step_req(step_req),
    .instr_byte_valid(instr_byte_valid), .device_reset_req(rst_req), .rx_byte(rx_byte),
    .cpu_pc(cpu_pc), .mem_rdata(mem_rdata), .instr_len(instr_len), .instr_done(instr_done),
    .device_reset_done(rst_done), .tx_ready(tx_ready));
  // ==========================================
  // Clock and hang guard
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 30000) begin
      err_total++;
      close_out();
    end
  end
  // ==========================================
  // Byte tasks and expectations
  task automatic cmp(input string nm, input logic [15:0] e, input logic [15:0] s);
    checks++;
    if (s !== e) begin
      err_total++;
      $display("wrong value %s exp %h got %h", nm, e, s);
    end
  endtask
  task automatic put(input logic [7:0] d);
    @(posedge core_clk);
    rx_byte <= d;
    rx_valid <= 1'b1;
    @(posedge core_clk);
    rx_valid <= 1'b0;
  endtask
  // Bounded wait: a reply that never comes counts as a mismatch
  task automatic get(output logic [7:0] d);
    int n;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (!(tx_valid === 1'b1 && tx_ready === 1'b1) && n < 400);
    if (n >= 400) err_total++;
    d = tx_byte;
  endtask
  task automatic get16(input logic [7:0] c, output logic [15:0] v);
    put(c);
    get(v[15:8]);
    get(v[7:0]);
  endtask
  task automatic rd8(input logic [7:0] c, input logic [7:0] e, input logic [7:0] m);
    logic [7:0] d;
    put(c);
    get(d);
    cmp("byte", {8'h00, e & m}, {8'h00, d & m});
  endtask
  // Register commands frame a 12-bit address and 8-bit size, memory ones 16 and 16
  task automatic xfer(input logic [7:0] c, input logic [15:0] ad, input int n, input bit rd,
      input bit ok);
    logic [7:0] d;
    logic [15:0] x;
    put(c);
    put((c == CMD_RREG || c == CMD_WREG) ? {4'h0, ad[11:8]} : ad[15:8]);
    put(ad[7:0]);
    if (!(c == CMD_RREG || c == CMD_WREG)) put(8'h00);
    put(8'(n));
    for (int i = 0; i < n; i++) begin
      x = ad + 16'(i);
      if (rd) begin
        get(d);
        cmp("mem", {8'h00, ok ? x[7:0] ^ 8'h5A : ALL_ONES_BYTE}, {8'h00, d});
      end else begin
        put(8'($random(seed)));
      end
    end
  endtask
  function automatic logic [15:0] exp_crc();
    logic [15:0] c;
    logic [7:0] d;
    c = CRC_INIT;
    for (int i = 0; i <= int'(PMB); i++) begin
      d = 8'(i) ^ 8'h5A;
      for (int k = 7; k >= 0; k--) c = {c[14:0], 1'b0} ^ ((c[15] ^ d[k]) ? CRC_POLY : 16'h0);
    end
    return c;
  endfunction
  task automatic pulse_brk;
    @(posedge core_clk);
    break_opcode <= 1'b1;
    @(posedge core_clk);
    break_opcode <= 1'b0;
  endtask
  task automatic close_out;
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ==========================================
  // Main sequence
  initial begin
    seed = 52192;
    {rx_valid, rx_byte, break_opcode, lock, fl_unl, err_total, checks, cyc} = '0;
    lph = 1'($random(seed));
    sys_rst = 1'b1;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    rd8(CMD_RCTL, CTL_RESET, 8'hFF);
    get16(CMD_REV, v1);
    cmp("rev", REV_DEFAULT, v1);
    put(8'h01);
    rd8(CMD_STAT, {1'b0, lph, 6'h0}, 8'hDF);
    get16(CMD_RTC, v1);
    get16(CMD_RTC, v2);
    cmp("rtc_run", 16'h1, 16'(v2 > v1));
    get16(CMD_RPC, v1);
    cmp("pc_run", 16'hFFFF, v1);
    a = 16'($random(seed));
    xfer(CMD_RDM, a, 2, 1, 0);
    get16(CMD_CRC, v1);
    cmp("crc_run", 16'hFFFF, v1);
    put(CMD_WCTL);
    put(8'h80);
    get16(CMD_RTC, v1);
    get16(CMD_RTC, v2);
    cmp("rtc_halt", v1, v2);
    rd8(CMD_STAT, {1'b1, lph, 6'h0}, 8'hDF);
    a = 16'($random(seed));
    put(CMD_WPC);
    put(a[15:8]);
    put(a[7:0]);
    get16(CMD_RPC, v1);
    cmp("pc", a, v1);
    xfer(CMD_RDM, a, 3, 1, 1);
    xfer(CMD_RREG, a, 2, 1, 1);
    xfer(CMD_RPM, a, 2, 1, 1);
    xfer(CMD_WREG, a, 2, 0, 1);
    xfer(CMD_WDM, a, 2, 0, 1);
    xfer(CMD_WPM, a, 2, 0, 1);
    fl_unl <= 1'b1;
    xfer(CMD_WPM, a, 1, 0, 1);
    put(CMD_STEP);
    get16(CMD_RPC, v1);
    cmp("pc_step", a + 16'h1, v1);
    put(CMD_STUFF);
    put(8'($random(seed)));
    b = 8'($random(seed));
    put(CMD_EXEC);
    put(b);
    for (int i = 0; i < int'(b[1:0]); i++) put(8'($random(seed)));
    rd8(CMD_RCTL, 8'h80, 8'hFF);
    get16(CMD_CRC, v1);
    cmp("crc", exp_crc(), v1);
    // Breakpoint with notify, then breakpoint disabled
    put(CMD_WCTL);
    put(8'h60);
    pulse_brk();
    get(b);
    cmp("notify", {8'h00, NOTIFY_BYTE}, {8'h00, b});
    rd8(CMD_RCTL, 8'hE0, 8'hFF);
    put(CMD_WCTL);
    put(8'h00);
    pulse_brk();
    rd8(CMD_RCTL, 8'h00, 8'hFF);
    put(CMD_WCTL);
    put(8'h81);
    repeat (40) @(posedge core_clk);
    rd8(CMD_RCTL, 8'h80, 8'hFF);
    // Read lock while halted
    lock <= 1'b1;
    put(CMD_WCTL);
    put(8'h00);
    rd8(CMD_RCTL, 8'h80, 8'h80);
    get16(CMD_RPC, v1);
    cmp("pc_lock", 16'hFFFF, v1);
    xfer(CMD_RREG, a, 2, 1, 0);
    xfer(CMD_RPM, a, 2, 1, 0);
    xfer(CMD_RDM, a, 2, 1, 1);
    xfer(CMD_WREG, 16'h0FF8, 1, 0, 1);
    xfer(CMD_WREG, a, 1, 0, 1);
    put(CMD_EXEC);
    put(8'h03);
    rd8(CMD_RCTL, 8'h80, 8'h80);
    lock <= 1'b0;
    sys_rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    rd8(CMD_RCTL, CTL_RESET, 8'hFF);
    close_out();
  end
endmodule
`default_nettype wire
